// ===== design/tmsc_pkg.sv
// Package with register map, field positions and shared types of the mode/sync control block
package tmsc_pkg;
    localparam int TMSC_NCH = 8;
    localparam logic [7:0] TMSC_OFS_MODE = 8'h00;
    localparam logic [7:0] TMSC_OFS_SYNC = 8'h04;
    localparam logic [7:0] TMSC_OFS_PRESET = 8'h08;
    localparam logic [7:0] TMSC_OFS_MASK = 8'h0c;
    localparam logic [7:0] TMSC_OFS_WPON = 8'h10;
    localparam logic [7:0] TMSC_OFS_STAT = 8'h14;
    localparam logic [7:0] TMSC_MODE_RST = 8'h04;
    localparam logic [7:0] TMSC_SYNC_RST = 8'h00;
    localparam logic [7:0] TMSC_PRESET_RST = 8'h00;
    localparam logic [7:0] TMSC_MASK_RST = 8'h00;
    // Mode register fields
    localparam int TMSC_B_FIE = 7;
    localparam int TMSC_B_FM_HI = 6;
    localparam int TMSC_B_FM_LO = 5;
    localparam int TMSC_B_CAPT = 4;
    localparam int TMSC_B_POL = 3;
    localparam int TMSC_B_WPOFF = 2;
    localparam int TMSC_B_INIT = 1;
    localparam int TMSC_B_EXT = 0;
    // Sync register fields
    localparam int TMSC_B_SW = 7;
    localparam int TMSC_B_HW_SYNC_SELECT_0 = 4;
    localparam int TMSC_B_MSYNC = 3;
    localparam int TMSC_B_COUNTER_RELOAD_ON_SYNC = 2;
    localparam int TMSC_B_TOP = 1;
    localparam int TMSC_B_BOT = 0;

    typedef enum logic [1:0] {
        TMSC_FM_OFF = 2'b00,
        TMSC_FM_EVEN_MAN = 2'b01,
        TMSC_FM_ALL_MAN = 2'b10,
        TMSC_FM_ALL_AUTO = 2'b11
    } tmsc_fm_t;

    typedef struct packed {
        logic load_limits;
        logic counter_reload;
        logic mask_load;
    } tmsc_upd_t;

    typedef struct packed {
        logic fault_enable;
        logic even_only;
        logic auto_clear;
    } tmsc_fault_t;
endpackage : tmsc_pkg

// ===== design/tmsc_trig_edge.sv
// Rising edge detector for the external synchronization trigger inputs
`timescale 1ns/1ps
module tmsc_trig_edge #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise
);
    logic [WIDTH-1:0] last;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            last <= '0;
        end else begin
            last <= level;
        end
    end

    assign rise = level & ~last;
endmodule : tmsc_trig_edge

// ===== design/tmsc_ctrl.sv
// Timer features mode, PWM synchronization, output preset and output mask control
// Operation
// - Fault irq raised on fault only when irq enable set and fault control on.
// - Fault mode: 00 off, 01 even manual, 10 all manual, 11 all auto.
// - Fault mode field written only while write protection is off.
// - Capture test enable bit; writable only while write protection is off.
// - Policy 0: all triggers drive all updates; 1: split soft and hard roles.
// - Protect-off reads as inverse of protect-on; writing 1 to protect-on clears it.
// - Protect-off set only after protect-on read as 1 then 1 written.
// - Writing 1 to init strobe forces unmasked outputs to presets; strobe reads 0.
// - Extended enable selects full register set; written only when unprotected.
// - Writing 1 to soft sync bit is a soft trigger when selected.
// - Selected external trigger rising edge is a synchronization trigger.
// - Mask loads from buffer every clock, or only on sync when selected.
// - Reload bit loads counter with start value on selected trigger.
// - Top boundary: after sync, limits load when counter reaches period.
// - Bottom boundary: after sync, limits load when counter reaches start value.
// - Each preset bit is the level driven on its channel at init, unless that channel is masked.
// - Mask writes go to a buffer; active mask follows sync rules.
// - Masked channel output is forced to its inactive level.
`timescale 1ns/1ps
module tmsc_ctrl
    import tmsc_pkg::*;
#(
    parameter int NCH = TMSC_NCH,
    parameter int NTRIG = 3
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic HSEL,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [NTRIG-1:0] EXT_TRIG,
    input wire logic FAULT_DETECT,
    input wire logic [NCH-1:0] CHAN_PWM,
    input wire logic [NCH-1:0] CHAN_INACTIVE,
    input wire logic AT_TOP,
    input wire logic AT_BOTTOM,
    output logic FAULT_IRQ,
    output logic [1:0] FAULT_MODE,
    output logic FAULT_ENABLE,
    output logic FAULT_EVEN_ONLY,
    output logic FAULT_AUTO_CLEAR,
    output logic CAPTURE_TEST,
    output logic EXTENDED_FEATURES,
    output logic COUNTER_RELOAD,
    output logic LIMITS_LOAD,
    output logic [NCH-1:0] CHAN_OUT
);
    // Register state
    logic fault_irq_enable;
    tmsc_fm_t fault_ctrl_select;
    logic capture_test_enable;
    logic sync_trigger_policy;
    logic write_protect_off;
    logic extended_features_enable;
    logic [7:0] sync_ctrl;
    logic [NCH-1:0] chan_preset_value;
    logic [NCH-1:0] mask_buffer;
    logic [NCH-1:0] chan_output_mask;
    logic wp_on_seen;
    logic limits_pending;
    logic init_hold;
    logic [NCH-1:0] chan_level;

    // AHB-Lite address phase capture
    logic dp_write;
    logic [7:0] dp_addr;

    wire logic access = HSEL & HREADY & HTRANS[1];
    wire logic [7:0] acc_addr = HADDR[7:0];
    wire logic mapped = (acc_addr[1:0] == 2'b00) && (acc_addr <= TMSC_OFS_STAT);

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end else begin
            dp_write <= access & HWRITE & mapped;
            dp_addr <= acc_addr;
        end
    end

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction : hit

    wire logic wr_mode = dp_write & hit(dp_addr, TMSC_OFS_MODE);
    wire logic wr_sync = dp_write & hit(dp_addr, TMSC_OFS_SYNC);
    wire logic wr_preset = dp_write & hit(dp_addr, TMSC_OFS_PRESET);
    wire logic wr_mask = dp_write & hit(dp_addr, TMSC_OFS_MASK);
    wire logic wr_wpon = dp_write & hit(dp_addr, TMSC_OFS_WPON);
    wire logic [7:0] wd = HWDATA[7:0];

    // Read of the protect-on register in the address phase arms the unlock
    wire logic rd_wpon_now = access & ~HWRITE & hit(acc_addr, TMSC_OFS_WPON);
    wire logic write_protect_on = ~write_protect_off;

    // Trigger detection
    logic [NTRIG-1:0] trig_rise;

    tmsc_trig_edge #(
        .WIDTH(NTRIG)
    ) u_edge (
        .clk(CLK),
        .nrst(NRST),
        .level(EXT_TRIG),
        .rise(trig_rise)
    );

    wire logic soft_trig = wr_sync & wd[TMSC_B_SW] & sync_ctrl[TMSC_B_SW];
    wire logic hard_trig = |(trig_rise & sync_ctrl[TMSC_B_HW_SYNC_SELECT_0 +: NTRIG]);
    // Policy 1 splits the trigger roles; policy 0 lets either drive all
    wire logic any_trig = soft_trig | hard_trig;
    tmsc_upd_t upd;
    assign upd.load_limits = sync_trigger_policy ? soft_trig : any_trig;
    assign upd.counter_reload = sync_trigger_policy ? hard_trig : any_trig;
    assign upd.mask_load = sync_trigger_policy ? hard_trig : any_trig;

    wire logic boundary_hit = (sync_ctrl[TMSC_B_TOP] & AT_TOP)
        | (sync_ctrl[TMSC_B_BOT] & AT_BOTTOM);
    wire logic limits_pending_any = limits_pending | upd.load_limits;
    wire logic next_limits_load = limits_pending_any & boundary_hit;
    wire logic next_limits_pending = limits_pending_any & ~boundary_hit;

    wire logic next_mask_take = ~sync_ctrl[TMSC_B_MSYNC] | upd.mask_load;
    // Mask write and its load in the same cycle: the newly written value wins
    wire logic [NCH-1:0] mask_src = wr_mask ? wd[NCH-1:0] : mask_buffer;

    tmsc_fault_t fault;
    assign fault.fault_enable = fault_ctrl_select != TMSC_FM_OFF;
    assign fault.even_only = fault_ctrl_select == TMSC_FM_EVEN_MAN;
    assign fault.auto_clear = fault_ctrl_select == TMSC_FM_ALL_AUTO;

    wire logic next_fault_irq = fault_irq_enable & fault.fault_enable & FAULT_DETECT;

    // Mode register writes, protected fields gated by write protection
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            fault_irq_enable <= TMSC_MODE_RST[TMSC_B_FIE];
            fault_ctrl_select <= tmsc_fm_t'(TMSC_MODE_RST[TMSC_B_FM_HI:TMSC_B_FM_LO]);
            capture_test_enable <= TMSC_MODE_RST[TMSC_B_CAPT];
            sync_trigger_policy <= TMSC_MODE_RST[TMSC_B_POL];
            extended_features_enable <= TMSC_MODE_RST[TMSC_B_EXT];
        end else if (wr_mode) begin
            fault_irq_enable <= wd[TMSC_B_FIE];
            sync_trigger_policy <= wd[TMSC_B_POL];
            if (write_protect_off) begin
                fault_ctrl_select <= tmsc_fm_t'(wd[TMSC_B_FM_HI:TMSC_B_FM_LO]);
                capture_test_enable <= wd[TMSC_B_CAPT];
                extended_features_enable <= wd[TMSC_B_EXT];
            end
        end
    end

    // Protection handshake
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            write_protect_off <= TMSC_MODE_RST[TMSC_B_WPOFF];
            wp_on_seen <= 1'b0;
        end else begin
            if (wr_wpon && wd[0]) begin
                write_protect_off <= 1'b0;
                wp_on_seen <= 1'b0;
            end else if (wr_mode && wd[TMSC_B_WPOFF] && wp_on_seen) begin
                write_protect_off <= 1'b1;
                wp_on_seen <= 1'b0;
            end else if (rd_wpon_now && write_protect_on) begin
                wp_on_seen <= 1'b1;
            end
        end
    end

    // Sync control, preset and mask buffer
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            sync_ctrl <= TMSC_SYNC_RST;
            chan_preset_value <= TMSC_PRESET_RST[NCH-1:0];
            mask_buffer <= TMSC_MASK_RST[NCH-1:0];
            chan_output_mask <= TMSC_MASK_RST[NCH-1:0];
            limits_pending <= 1'b0;
        end else begin
            if (wr_sync) begin
                sync_ctrl <= wd;
            end
            if (wr_preset) begin
                chan_preset_value <= wd[NCH-1:0];
            end
            if (wr_mask) begin
                mask_buffer <= wd[NCH-1:0];
            end
            if (next_mask_take) begin
                chan_output_mask <= mask_src;
            end
            limits_pending <= next_limits_pending;
        end
    end

    // Channel output: init forces presets, then mask forces inactive level
    wire logic init_strobe = wr_mode & wd[TMSC_B_INIT];
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_chan
            wire logic base = init_hold ? chan_level[ch] : CHAN_PWM[ch];
            wire logic next_level = init_strobe ? chan_preset_value[ch] : base;
            wire logic next_out = chan_output_mask[ch] ? CHAN_INACTIVE[ch] : next_level;
            always_ff @(posedge CLK or negedge NRST) begin
                if (!NRST) begin
                    chan_level[ch] <= 1'b0;
                    CHAN_OUT[ch] <= 1'b0;
                end else begin
                    chan_level[ch] <= next_level;
                    CHAN_OUT[ch] <= next_out;
                end
            end
        end
    endgenerate

    // Preset level holds until a counter reload trigger, or until CHAN_PWM differs from the held level
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            init_hold <= 1'b0;
        end else if (init_strobe) begin
            init_hold <= 1'b1;
        end else if (upd.counter_reload || CHAN_PWM != chan_level) begin
            init_hold <= 1'b0;
        end
    end

    // Registered control outputs
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            FAULT_IRQ <= 1'b0;
            FAULT_MODE <= 2'b00;
            FAULT_ENABLE <= 1'b0;
            FAULT_EVEN_ONLY <= 1'b0;
            FAULT_AUTO_CLEAR <= 1'b0;
            CAPTURE_TEST <= 1'b0;
            EXTENDED_FEATURES <= 1'b0;
            COUNTER_RELOAD <= 1'b0;
            LIMITS_LOAD <= 1'b0;
        end else begin
            FAULT_IRQ <= next_fault_irq;
            FAULT_MODE <= fault_ctrl_select;
            FAULT_ENABLE <= fault.fault_enable;
            FAULT_EVEN_ONLY <= fault.even_only;
            FAULT_AUTO_CLEAR <= fault.auto_clear;
            CAPTURE_TEST <= capture_test_enable;
            EXTENDED_FEATURES <= extended_features_enable;
            COUNTER_RELOAD <= upd.counter_reload & sync_ctrl[TMSC_B_COUNTER_RELOAD_ON_SYNC];
            LIMITS_LOAD <= next_limits_load;
        end
    end

    // Read mux, registered in the data phase
    wire logic [7:0] mode_rd = {fault_irq_enable, fault_ctrl_select, capture_test_enable,
        sync_trigger_policy, write_protect_off, 1'b0, extended_features_enable};
    wire logic [7:0] stat_rd = {5'h00, limits_pending, init_hold, FAULT_IRQ};
    logic [7:0] rd_sel;
    always_comb begin
        unique case (acc_addr)
            TMSC_OFS_MODE: rd_sel = mode_rd;
            TMSC_OFS_SYNC: rd_sel = sync_ctrl;
            TMSC_OFS_PRESET: rd_sel = chan_preset_value;
            TMSC_OFS_MASK: rd_sel = mask_buffer;
            TMSC_OFS_WPON: rd_sel = {7'h00, write_protect_on};
            TMSC_OFS_STAT: rd_sel = stat_rd;
            default: rd_sel = 8'h00;
        endcase
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            HRDATA <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            HRDATA <= (access & ~HWRITE) ? {24'h00_0000, rd_sel} : 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end
endmodule : tmsc_ctrl

// ===== testbench/tmsc_ctrl_assertions.sv
// Concurrent checks on the ports of the timer mode and sync control block
`timescale 1ns/1ps
module tmsc_ctrl_chk
    import tmsc_pkg::*;
#(
    parameter int NCH = TMSC_NCH,
    parameter int NTRIG = 3
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HSEL,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [NTRIG-1:0] EXT_TRIG,
    input wire logic FAULT_DETECT,
    input wire logic AT_TOP,
    input wire logic AT_BOTTOM,
    input wire logic FAULT_IRQ,
    input wire logic [1:0] FAULT_MODE,
    input wire logic FAULT_ENABLE,
    input wire logic FAULT_EVEN_ONLY,
    input wire logic FAULT_AUTO_CLEAR,
    input wire logic CAPTURE_TEST,
    input wire logic EXTENDED_FEATURES,
    input wire logic COUNTER_RELOAD,
    input wire logic LIMITS_LOAD
);
    logic rd_q;
    logic wr_q;
    logic [NTRIG-1:0] ext_q;
    logic [3:0] hist;
    wire addr_phase = HSEL && HREADY && HTRANS[1];
    wire trig_seen = (|(EXT_TRIG & ~ext_q)) || wr_q;
    // History of possible causes, so a reload with no recent trigger is caught
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rd_q <= 1'h0;
            wr_q <= 1'h0;
            ext_q <= {NTRIG{1'h0}};
            hist <= 4'h0;
        end else begin
            rd_q <= addr_phase && !HWRITE;
            wr_q <= addr_phase && HWRITE;
            ext_q <= EXT_TRIG;
            hist <= {hist[2:0], trig_seen};
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    sequence s_bus_idle;
        !rd_q;
    endsequence
    bus_okay_a: assert property (HREADYOUT && !HRESP)
        else $error("bus slave not ready or not okay");
    rdata_idle_a: assert property (s_bus_idle |-> HRDATA == 32'h0)
        else $error("read data outside data phase");
    rdata_upper_a: assert property (HRDATA[31:8] == 24'h0)
        else $error("upper read data bits set");
    fault_irq_a: assert property (FAULT_IRQ |-> $past(FAULT_DETECT) && FAULT_ENABLE)
        else $error("fault irq without fault or enable");
    fault_decode_a: assert property (FAULT_ENABLE == (FAULT_MODE != 2'h0)
        && FAULT_EVEN_ONLY == (FAULT_MODE == 2'h1) && FAULT_AUTO_CLEAR == (FAULT_MODE == 2'h3))
        else $error("fault mode decode wrong");
    cfg_change_a: assert property ($changed({FAULT_MODE, CAPTURE_TEST, EXTENDED_FEATURES})
        |-> $past(wr_q) || $past(wr_q, 2)) else $error("mode output changed without write");
    limits_cause_a: assert property (LIMITS_LOAD |-> $past(AT_TOP || AT_BOTTOM))
        else $error("limits load without boundary");
    reload_cause_a: assert property (COUNTER_RELOAD |-> |hist)
        else $error("counter reload without trigger");
endmodule : tmsc_ctrl_chk

bind tmsc_ctrl tmsc_ctrl_chk #(.NCH(NCH), .NTRIG(NTRIG)) u_chk (.CLK(CLK), .NRST(NRST),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSEL(HSEL), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .EXT_TRIG(EXT_TRIG), .FAULT_DETECT(FAULT_DETECT),
    .AT_TOP(AT_TOP), .AT_BOTTOM(AT_BOTTOM), .FAULT_IRQ(FAULT_IRQ), .FAULT_MODE(FAULT_MODE),
    .FAULT_ENABLE(FAULT_ENABLE), .FAULT_EVEN_ONLY(FAULT_EVEN_ONLY),
    .FAULT_AUTO_CLEAR(FAULT_AUTO_CLEAR), .CAPTURE_TEST(CAPTURE_TEST),
    .EXTENDED_FEATURES(EXTENDED_FEATURES), .COUNTER_RELOAD(COUNTER_RELOAD),
    .LIMITS_LOAD(LIMITS_LOAD));

// ===== testbench/testbench.sv
// Self-checking bench for the timer mode and sync control block
`timescale 1ns/1ps
module testbench;
    import tmsc_pkg::*;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic hsel = 1'h0;
    logic hwrite = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [2:0] ext = 3'h0;
    logic fdet = 1'h0;
    logic top = 1'h0;
    logic bot = 1'h0;
    logic [7:0] pwm = 8'h0;
    logic [7:0] inact = 8'h0;
    wire hready, hresp, fen, feven, fauto, firq, capt, extf, reload, limits;
    wire [31:0] hrdata;
    wire [1:0] fmode;
    wire [7:0] cout;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;
    int n_rel = 0;
    int n_lim = 0;
    tmsc_ctrl dut (.CLK(clk), .NRST(nrst), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HSEL(hsel), .HREADY(hready), .HWDATA(hwdata), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp), .EXT_TRIG(ext), .FAULT_DETECT(fdet),
        .CHAN_PWM(pwm), .CHAN_INACTIVE(inact), .AT_TOP(top), .AT_BOTTOM(bot),
        .FAULT_IRQ(firq), .FAULT_MODE(fmode), .FAULT_ENABLE(fen), .FAULT_EVEN_ONLY(feven),
        .FAULT_AUTO_CLEAR(fauto), .CAPTURE_TEST(capt), .EXTENDED_FEATURES(extf),
        .COUNTER_RELOAD(reload), .LIMITS_LOAD(limits), .CHAN_OUT(cout));
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One single transfer; a read compares the data phase value with d
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge clk);
        while (hready !== 1'h1) @(posedge clk);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge clk);
        while (hready !== 1'h1) @(posedge clk);
        if (!w) chk($sformatf("reg %h", a), {24'h0, d}, hrdata);
    endtask : acc
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // A one-cycle high pulse: 0 to 2 select a trigger input, 3 the top flag, 4 the bottom flag
    task automatic pulse_edge(input int sel);
        if (sel < 3) begin
            ext[sel] <= 1'h1;
        end else if (sel == 3) begin
            top <= 1'h1;
        end else begin
            bot <= 1'h1;
        end
        tick(1);
        ext <= 3'h0;
        top <= 1'h0;
        bot <= 1'h0;
        tick(3);
    endtask : pulse_edge
    task automatic t_prot();
        acc(0, TMSC_OFS_MODE, TMSC_MODE_RST);
        acc(0, TMSC_OFS_SYNC, TMSC_SYNC_RST);
        acc(0, TMSC_OFS_PRESET, TMSC_PRESET_RST);
        acc(0, TMSC_OFS_MASK, TMSC_MASK_RST);
        acc(0, 8'h18, 8'h00);
        acc(0, TMSC_OFS_STAT, 8'h00);
        acc(1, TMSC_OFS_WPON, 8'h01);
        acc(0, TMSC_OFS_MODE, 8'h00);
        acc(1, TMSC_OFS_MODE, 8'hf5);
        acc(0, TMSC_OFS_MODE, 8'h80);
        tick(2);
        chk("fault mode", 2'h0, fmode);
        chk("capture", 1'h0, capt);
        chk("extended", 1'h0, extf);
        acc(0, TMSC_OFS_WPON, 8'h01);
        acc(1, TMSC_OFS_MODE, 8'h80);
        acc(0, TMSC_OFS_MODE, 8'h80);
        acc(0, TMSC_OFS_WPON, 8'h01);
        acc(1, TMSC_OFS_MODE, 8'hf5);
        acc(0, TMSC_OFS_MODE, 8'h84);
        acc(0, TMSC_OFS_WPON, 8'h00);
        acc(1, TMSC_OFS_MODE, 8'hf5);
        tick(2);
        chk("capture on", 1'h1, capt);
        chk("extended on", 1'h1, extf);
        $display("test protection done");
    endtask : t_prot
    task automatic t_fault();
        // Pass 4 repeats mode 11 with the irq enable cleared
        for (int m = 0; m < 5; m++) begin
            acc(1, TMSC_OFS_MODE, {m < 4, m == 4 ? 2'h3 : 2'(m), 5'h04});
            fdet <= 1'h1;
            tick(3);
            chk("fault mode", m == 4 ? 2'h3 : 2'(m), fmode);
            chk("fault on", m != 0, fen);
            chk("even only", m == 1, feven);
            chk("auto clear", m >= 3, fauto);
            chk("fault irq", m > 0 && m < 4, firq);
            fdet <= 1'h0;
        end
        $display("test fault modes done");
    endtask : t_fault
    task automatic t_init();
        acc(1, TMSC_OFS_PRESET, 8'ha5);
        acc(1, TMSC_OFS_MODE, 8'h06);
        tick(2);
        chk("preset out", 8'ha5, cout);
        acc(0, TMSC_OFS_MODE, 8'h04);
        pwm <= 8'h3c;
        tick(3);
        chk("pwm out", 8'h3c, cout);
        $display("test init done");
    endtask : t_init
    task automatic t_mask();
        inact <= 8'h0f;
        pwm <= 8'hf0;
        acc(1, TMSC_OFS_MASK, 8'h33);
        tick(3);
        chk("mask each clock", 8'hc3, cout);
        acc(1, TMSC_OFS_SYNC, 8'h18);
        acc(1, TMSC_OFS_MASK, 8'hff);
        tick(3);
        chk("mask held", 8'hc3, cout);
        pulse_edge(0);
        chk("mask synced", 8'h0f, cout);
        $display("test mask done");
    endtask : t_mask
    task automatic t_reload();
        int b;
        b = n_rel;
        acc(1, TMSC_OFS_SYNC, 8'h24);
        pulse_edge(1);
        chk("reload hw", b + 1, n_rel);
        pulse_edge(2);
        chk("reload unselected", b + 1, n_rel);
        acc(1, TMSC_OFS_SYNC, 8'h84);
        acc(1, TMSC_OFS_SYNC, 8'h84);
        tick(3);
        chk("reload sw", b + 2, n_rel);
        acc(1, TMSC_OFS_MODE, 8'h0c);
        acc(1, TMSC_OFS_SYNC, 8'h84);
        tick(3);
        chk("split sw", b + 2, n_rel);
        acc(1, TMSC_OFS_SYNC, 8'h14);
        pulse_edge(0);
        chk("split hw", b + 3, n_rel);
        acc(1, TMSC_OFS_MODE, 8'h04);
        $display("test reload done");
    endtask : t_reload
    task automatic t_limits();
        int b;
        b = n_lim;
        acc(1, TMSC_OFS_SYNC, 8'h82);
        acc(1, TMSC_OFS_SYNC, 8'h82);
        tick(2);
        chk("no early load", b, n_lim);
        pulse_edge(3);
        chk("top load", b + 1, n_lim);
        acc(1, TMSC_OFS_SYNC, 8'h81);
        pulse_edge(4);
        chk("bottom load", b + 2, n_lim);
        $display("test limits done");
    endtask : t_limits
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (reload === 1'h1) n_rel++;
        if (limits === 1'h1) n_lim++;
        if (cycles == 5000) begin
            fails++;
            results();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
        t_prot();
        t_fault();
        t_init();
        t_mask();
        t_reload();
        t_limits();
        results();
    end
endmodule : testbench
